// >>> verilog/epi_map.svh
`ifndef EPI_MAP_SVH
`define EPI_MAP_SVH
// Register byte offsets on the AHB-Lite slave.
`define EPI_OFS_MODE 12'h000
`define EPI_OFS_IM 12'h004
`define EPI_OFS_RIS 12'h008
`define EPI_OFS_MIS 12'h00c
`define EPI_OFS_ERR 12'h010
`define EPI_OFS_ERRCLR 12'h014
`define EPI_OFS_MAXWAIT 12'h018
`define EPI_OFS_FIFOLVL 12'h01c
`define EPI_OFS_RXTRIG 12'h020
`define EPI_OFS_TXTRIG 12'h024
`define EPI_OFS_RDFIFO 12'h028
`define EPI_OFS_CH0CFG 12'h030
`define EPI_OFS_CH0ADDR 12'h034
`define EPI_OFS_CH0CNT 12'h038
`define EPI_OFS_CH0STOP 12'h03c
`define EPI_CH_STRIDE 12'h010
// Field positions.
`define EPI_BIT_TXREQ 0
`define EPI_BIT_RXREQ 1
`define EPI_BIT_ERR 2
`define EPI_BIT_WTFULL 0
`define EPI_BIT_RSTALL 1
`define EPI_BIT_TIMEOUT 2
// Reset values.
`define EPI_RST_MODE 5'h10
`define EPI_RST_MAXWAIT 16'h0000
`define EPI_RST_RXTRIG 8'h04
`define EPI_RST_TXTRIG 8'h02
// Timing: external interface needs one cycle per item.
`define EPI_ITEM_NS 8
`define EPI_CLK_NS 8
`define EPI_ITEM_CYC ((`EPI_ITEM_NS + `EPI_CLK_NS - 1) / `EPI_CLK_NS)
`endif

// >>> verilog/epi_pkg.sv
package epi_pkg;
  // One-hot operating mode codes.
  typedef enum logic [4:0] {
    mode_general_purpose = 5'h01,
    mode_sync_dram = 5'h02,
    mode_host_bus_narrow = 5'h04,
    mode_host_bus_wide = 5'h08,
    mode_off = 5'h10
  } epi_mode_e;
  // Item size codes.
  typedef enum logic [1:0] {
    item_size_byte = 2'h0,
    item_size_half = 2'h1,
    item_size_word = 2'h2
  } epi_size_e;
  // Channel fetch state.
  typedef enum logic [1:0] {
    ch_idle = 2'h1,
    ch_busy = 2'h2
  } epi_ch_state_e;
  typedef logic [31:0] epi_word_t;
endpackage : epi_pkg

// >>> verilog/epi_fetch_if.sv
`timescale 1ns/10ps
// Fetch request and grant between a read channel and the arbiter.
interface epi_fetch_if;
  logic req;
  logic gnt;
  logic [31:0] addr;
  logic [1:0] size;
  modport chan (output req, output addr, output size, input gnt);
  modport arb (input req, input addr, input size, output gnt);
endinterface : epi_fetch_if

// >>> verilog/epi_rd_chan.sv
`timescale 1ns/10ps
`include "epi_map.svh"
module epi_rd_chan (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cfg_we,
  input wire logic [1:0] cfg_size,
  input wire logic addr_we,
  input wire logic [31:0] addr_wdata,
  input wire logic start,
  input wire logic [11:0] start_count,
  input wire logic stop,
  output logic [11:0] remaining,
  output logic [1:0] size_out,
  output logic [31:0] addr_out,
  epi_fetch_if.chan fetch
);
  import epi_pkg::*;
  epi_ch_state_e state_q;
  logic [11:0] remaining_q;
  logic [1:0] size_q;
  logic [31:0] addr_q;
  logic [2:0] step;

  // Address stride follows the item size.
  always_comb begin
    case (size_q)
      item_size_byte: step = 3'h1;
      item_size_half: step = 3'h2;
      default: step = 3'h4;
    endcase
  end

  // Size setting held per channel.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      size_q <= item_size_byte;
    end else if (cfg_we) begin
      size_q <= cfg_size;
    end
  end

  // Address kept across transactions and advanced per item.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= 32'h0;
    end else if (addr_we) begin
      addr_q <= addr_wdata;
    end else if (fetch.gnt) begin
      addr_q <= addr_q + {29'h0, step};
    end
  end

  // Count down items; stop cancels, zero count is ignored.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ch_idle;
      remaining_q <= 12'h0;
    end else begin
      case (state_q)
        ch_idle: begin
          if (start && !stop && start_count != 12'h0) begin
            state_q <= ch_busy;
            remaining_q <= start_count;
          end
        end
        ch_busy: begin
          if (stop) begin
            state_q <= ch_idle;
            remaining_q <= 12'h0;
          end else if (fetch.gnt) begin
            remaining_q <= remaining_q - 12'h1;
            if (remaining_q == 12'h1) begin
              state_q <= ch_idle;
            end
          end
        end
        default: state_q <= ch_idle;
      endcase
    end
  end

  assign fetch.req = (state_q == ch_busy) && !stop;
  assign fetch.addr = addr_q;
  assign fetch.size = size_q;
  assign remaining = remaining_q;
  assign size_out = size_q;
  assign addr_out = addr_q;

  // Each grant consumes one item.
  cnt_dec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    fetch.gnt && !stop |=> remaining_q == $past(remaining_q) - 12'h1)
    else $error("remaining count did not drop");
  stop_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    stop |=> !fetch.req && remaining_q == 12'h0)
    else $error("stop did not cancel channel");
  exact_cnt_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    state_q == ch_idle |-> remaining_q == 12'h0)
    else $error("channel went idle with items left");
  cover_done_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    state_q == ch_busy ##1 state_q == ch_idle);
endmodule : epi_rd_chan

// >>> verilog/epi_ctrl.sv
`timescale 1ns/10ps
`include "epi_map.svh"
// What this block does
// - Latch write-full error when a write stalls on a full transaction queue.
// - Latch read-stall error when an external read is held up.
// - Latch timeout error when ready holds off longer than max wait.
// - Errors stay pending until cleared by a write-one mask.
// - Summary error bit set while any error pending; error register shows causes.
// - Interrupt status readable raw and masked: transmit, receive, error.
// - Five one-hot modes: general, SDRAM, host-bus 8, host-bus 16, off.
// - Any mode but off enables the interface.
// - Read FIFO fill count is readable.
// - Only read-channel fetches fill the read FIFO.
// - Two independent read channels, 0 and 1.
// - Each channel holds an 8, 16 or 32-bit item size.
// - Each channel holds a device-relative start address.
// - Channel address persists and continues sequentially.
// - Remaining item count per channel, decrementing per fetch.
// - Start accepts count 1 to 4095 and fetches exactly that many.
// - Fetching pauses while read FIFO full and resumes on drain.
// - Transmit request below its trigger; receive request above its trigger.
// - Stop cancels a channel's transaction in progress.
module epi_ctrl #(
  parameter int FIFO_DEPTH = 8,
  parameter int TX_DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_ready,
  output logic ext_rd,
  output logic [31:0] ext_addr,
  output logic [1:0] ext_size,
  input wire logic [31:0] ext_rdata,
  input wire logic wr_attempt,
  input wire logic wr_queue_full,
  input wire logic [3:0] tx_level,
  output logic if_enable,
  output epi_pkg::epi_mode_e mode
);
  import epi_pkg::*;

  localparam int LW = $clog2(FIFO_DEPTH + 1);

  initial begin
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 255 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin
      $error("FIFO_DEPTH must be a power of two from 2 to 128");
    end
    if (TX_DEPTH < 1 || TX_DEPTH > 15) begin
      $error("TX_DEPTH must be 1 to 15");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  logic ph_q;
  logic ph_wr_q;
  logic [11:0] ph_addr_q;
  logic wr_en;
  logic rd_en;
  logic [11:0] a_addr;

  assign a_addr = haddr[11:0];

  // Capture each address phase; every access completes with no wait.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ph_q <= 1'b0;
      ph_wr_q <= 1'b0;
      ph_addr_q <= 12'h0;
    end else if (hready) begin
      ph_q <= hsel && htrans[1];
      ph_wr_q <= hwrite;
      ph_addr_q <= a_addr;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = ph_q && ph_wr_q;
  assign rd_en = hsel && htrans[1] && !hwrite && hready;

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers.

  epi_mode_e mode_q;
  logic [2:0] im_q;
  logic [15:0] maxwait_q;
  logic [7:0] rxtrig_q;
  logic [7:0] txtrig_q;

  // Mode and configuration registers.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_q <= mode_off;
      im_q <= 3'h0;
      maxwait_q <= `EPI_RST_MAXWAIT;
      rxtrig_q <= `EPI_RST_RXTRIG;
      txtrig_q <= `EPI_RST_TXTRIG;
    end else if (wr_en) begin
      case (ph_addr_q)
        `EPI_OFS_MODE: begin
          case (hwdata[4:0])
            5'h01, 5'h02, 5'h04, 5'h08, 5'h10: mode_q <= epi_mode_e'(hwdata[4:0]);
            default: mode_q <= mode_q;
          endcase
        end
        `EPI_OFS_IM: im_q <= hwdata[2:0];
        `EPI_OFS_MAXWAIT: maxwait_q <= hwdata[15:0];
        `EPI_OFS_RXTRIG: rxtrig_q <= hwdata[7:0];
        `EPI_OFS_TXTRIG: txtrig_q <= hwdata[7:0];
        default: mode_q <= mode_q;
      endcase
    end
  end

  assign if_enable = (mode_q != mode_off);
  assign mode = mode_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read channels.

  logic [1:0] ch_cfg_we;
  logic [1:0] ch_addr_we;
  logic [1:0] ch_start;
  logic [1:0] ch_stop;
  logic [11:0] ch_rem [2];
  logic [1:0] ch_gnt;
  logic [1:0] ch_req;
  logic [31:0] ch_addr [2];
  logic [1:0] ch_size [2];
  logic fifo_full;
  logic ext_busy_q;
  logic issue;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      epi_fetch_if fif ();
      localparam logic [11:0] BASE = `EPI_OFS_CH0CFG + 12'(g) * `EPI_CH_STRIDE;
      assign ch_cfg_we[g] = wr_en && ph_addr_q == BASE;
      assign ch_addr_we[g] = wr_en && ph_addr_q == BASE + 12'h4;
      assign ch_start[g] = wr_en && ph_addr_q == BASE + 12'h8;
      assign ch_stop[g] = wr_en && ph_addr_q == BASE + 12'hc;
      assign ch_req[g] = fif.req;
      assign ch_addr[g] = fif.addr;
      assign ch_size[g] = fif.size;
      assign fif.gnt = ch_gnt[g];
      // Two independent channels.
      epi_rd_chan u_chan (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .cfg_we(ch_cfg_we[g]),
        .cfg_size(hwdata[1:0]),
        .addr_we(ch_addr_we[g]),
        .addr_wdata(hwdata),
        .start(ch_start[g]),
        .start_count(hwdata[11:0]),
        .stop(ch_stop[g]),
        .remaining(ch_rem[g]),
        .size_out(),
        .addr_out(),
        .fetch(fif)
      );
    end
  endgenerate

  // Channel 0 first; a grant only while the FIFO has room.
  assign issue = if_enable && !ext_busy_q && !fifo_full;
  assign ch_gnt[0] = issue && ch_req[0] && ext_ready;
  assign ch_gnt[1] = issue && !ch_req[0] && ch_req[1] && ext_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // External read and wait counting.

  logic any_req;
  logic [15:0] wait_q;
  logic timeout;
  logic stall;
  logic got_item;
  logic [31:0] item_q;

  assign any_req = if_enable && (ch_req[0] || ch_req[1]) && !ext_busy_q;
  assign stall = any_req && !ext_ready;
  assign timeout = stall && maxwait_q != 16'h0 && wait_q >= maxwait_q;
  assign ext_rd = ch_gnt[0] || ch_gnt[1];
  assign ext_addr = ch_gnt[0] ? ch_addr[0] : ch_addr[1];
  assign ext_size = ch_gnt[0] ? ch_size[0] : ch_size[1];

  // Data is sampled in the strobe cycle and written to the FIFO the cycle after.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_busy_q <= 1'b0;
      got_item <= 1'b0;
      item_q <= 32'h0;
    end else begin
      ext_busy_q <= ext_rd && `EPI_ITEM_CYC > 1;
      got_item <= ext_rd;
      item_q <= ext_rdata;
    end
  end

  // Count clocks held off by the ready input.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 16'h0;
    end else if (stall && !timeout) begin
      wait_q <= wait_q + 16'h1;
    end else begin
      wait_q <= 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read FIFO, filled only by channel fetches.

  logic [31:0] mem [FIFO_DEPTH];
  logic [LW-1:0] cnt_q;
  logic [LW-2:0] wp_q;
  logic [LW-2:0] rp_q;
  logic pop;

  // An item still in flight already owns a slot, so it counts towards full.
  assign fifo_full = (cnt_q + LW'(got_item)) >= LW'(FIFO_DEPTH);
  assign pop = rd_en && a_addr == `EPI_OFS_RDFIFO && cnt_q != '0;

  // Write fetched items, pop on software read.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (got_item) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + LW'(got_item) - LW'(pop);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (got_item) begin
      mem[wp_q] <= item_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Error flags and interrupt status.

  logic [2:0] err_q;
  logic [2:0] err_set;
  logic [2:0] ris;

  assign err_set[`EPI_BIT_WTFULL] = wr_attempt && wr_queue_full;
  assign err_set[`EPI_BIT_RSTALL] = stall;
  assign err_set[`EPI_BIT_TIMEOUT] = timeout;

  // Sticky errors; a set in the clear cycle wins.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      err_q <= 3'h0;
    end else if (wr_en && ph_addr_q == `EPI_OFS_ERRCLR) begin
      err_q <= (err_q & ~hwdata[2:0]) | err_set;
    end else begin
      err_q <= err_q | err_set;
    end
  end

  assign ris[`EPI_BIT_TXREQ] = {4'h0, tx_level} < txtrig_q;
  assign ris[`EPI_BIT_RXREQ] = 8'(cnt_q) > rxtrig_q;
  assign ris[`EPI_BIT_ERR] = |err_q;

  // Read data mux; unmapped reads give zero.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0;
    end else if (rd_en) begin
      case (a_addr)
        `EPI_OFS_MODE: hrdata <= {27'h0, mode_q};
        `EPI_OFS_IM: hrdata <= {29'h0, im_q};
        `EPI_OFS_RIS: hrdata <= {29'h0, ris};
        `EPI_OFS_MIS: hrdata <= {29'h0, ris & im_q};
        `EPI_OFS_ERR: hrdata <= {29'h0, err_q};
        `EPI_OFS_MAXWAIT: hrdata <= {16'h0, maxwait_q};
        `EPI_OFS_FIFOLVL: hrdata <= 32'(cnt_q);
        `EPI_OFS_RXTRIG: hrdata <= {24'h0, rxtrig_q};
        `EPI_OFS_TXTRIG: hrdata <= {24'h0, txtrig_q};
        `EPI_OFS_RDFIFO: hrdata <= mem[rp_q];
        `EPI_OFS_CH0CNT: hrdata <= {20'h0, ch_rem[0]};
        `EPI_OFS_CH0CNT + `EPI_CH_STRIDE: hrdata <= {20'h0, ch_rem[1]};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  wtfull_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_attempt && wr_queue_full |=> err_q[`EPI_BIT_WTFULL])
    else $error("write-full error not latched");
  rstall_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    stall |=> err_q[`EPI_BIT_RSTALL])
    else $error("read-stall error not latched");
  timeout_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    stall && maxwait_q != 16'h0 && wait_q >= maxwait_q |=> err_q[`EPI_BIT_TIMEOUT])
    else $error("timeout error not latched");
  err_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    err_q[0] && !(wr_en && ph_addr_q == `EPI_OFS_ERRCLR) |=> err_q[0])
    else $error("error flag dropped without clear");
  err_sum_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ris[`EPI_BIT_ERR] == (err_q != 3'h0))
    else $error("summary error mismatch");
  en_mode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $onehot(mode_q) && (if_enable == !mode_q[4]))
    else $error("mode not one-hot or enable wrong");
  full_pause_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    fifo_full |-> !ext_rd)
    else $error("fetch while read FIFO full");
  fill_cnt_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    got_item && !pop |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("FIFO count did not rise");
  fifo_bound_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    cnt_q <= LW'(FIFO_DEPTH))
    else $error("read FIFO overfilled");
  cover_full_c: cover property (@(posedge ref_clk) disable iff (!nrst) fifo_full);
  cover_both_c: cover property (@(posedge ref_clk) disable iff (!nrst) ch_req == 2'b11);
  cover_clr_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    err_q[2] ##1 !err_q[2]);
endmodule : epi_ctrl

// >>> dv/ebsrc_ext_mem.sv
`timescale 1ns/10ps
// External memory on the parallel side: answers every fetch in the cycle it is made.
module ebsrc_ext_mem (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ext_rd,
  input wire logic [31:0] ext_addr,
  input wire logic [1:0] ext_size,
  input wire logic hold,
  input wire logic slow,
  output logic ext_ready,
  output logic [31:0] ext_rdata
);
  logic ph_q;
  logic [31:0] last_q;
  // Phase toggles every cycle so a slow device is ready only on alternate cycles.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ph_q <= 1'b0;
      last_q <= 32'h0;
    end else begin
      ph_q <= ~ph_q;
      if (ext_rd) begin
        last_q <= ext_rdata;
      end
    end
  end
  // Hold keeps ready low to stall the channel on purpose.
  assign ext_ready = ~hold & (~slow | ph_q);
  // Data is the inverted address cut to the item width; between fetches the bus shows the inverse of the last word.
  always_comb begin
    if (ext_rd) begin
      ext_rdata = ~ext_addr & ((ext_size == 2'h0) ? 32'hff : (ext_size == 2'h1) ? 32'hffff : 32'hffffffff);
    end else begin
      ext_rdata = ~last_q;
    end
  end
endmodule : ebsrc_ext_mem

// >>> dv/test_ext_bus_status_and_read_channels.sv
`timescale 1ns/10ps
`include "epi_map.svh"
module test_ext_bus_status_and_read_channels;
  import epi_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, ext_ready, ext_rd, if_enable;
  logic [31:0] hrdata, ext_addr, ext_rdata, rv;
  logic [1:0] ext_size;
  logic wr_attempt = 1'b0;
  logic wr_queue_full = 1'b0;
  logic [3:0] tx_level = 4'h4;
  logic hold = 1'b0;
  logic slow = 1'b0;
  epi_mode_e mode;
  logic [31:0] nxt [2];
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int rd_seen = 0;
  assign hready = hreadyout;
  always #4 ref_clk = ~ref_clk;
  epi_ctrl #(.FIFO_DEPTH(8)) dut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ext_ready(ext_ready), .ext_rd(ext_rd), .ext_addr(ext_addr), .ext_size(ext_size),
    .ext_rdata(ext_rdata), .wr_attempt(wr_attempt), .wr_queue_full(wr_queue_full), .tx_level(tx_level),
    .if_enable(if_enable), .mode(mode));
  ebsrc_ext_mem mem (.ref_clk(ref_clk), .nrst(nrst), .ext_rd(ext_rd), .ext_addr(ext_addr), .ext_size(ext_size),
    .hold(hold), .slow(slow), .ext_ready(ext_ready), .ext_rdata(ext_rdata));
  // Counts fetches on the external side and cuts a hung run short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (ext_rd === 1'b1) rd_seen <= rd_seen + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Prints the verdict and stops.
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // One AHB-Lite single word transfer; read data lands in rv.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rv = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask : rchk
  // Reads a register until it shows the wanted value.
  task automatic poll(input logic [11:0] a, input logic [31:0] exp);
    do bus(1'b0, a, 32'h0); while (rv !== exp);
  endtask : poll
  function automatic logic [11:0] chb(input int c);
    return `EPI_OFS_CH0CFG + 12'(c) * `EPI_CH_STRIDE;
  endfunction : chb
  // Configures a channel and starts a read of n items.
  task automatic go(input int c, input logic [1:0] s, input logic [31:0] a, input logic [31:0] n);
    wr(chb(c), {30'h0, s});
    wr(chb(c) + 12'h4, a);
    nxt[c] = a;
    wr(chb(c) + 12'h8, n);
  endtask : go
  // Pops n items and compares each against the inverted address it was fetched from, cut to the item width.
  task automatic pop(input int c, input logic [1:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      rchk(`EPI_OFS_RDFIFO, ~nxt[c] & ((s == 2'h0) ? 32'hff : (s == 2'h1) ? 32'hffff : 32'hffffffff));
      nxt[c] = nxt[c] + (32'h1 << s);
    end
  endtask : pop
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(`EPI_OFS_MODE, 32'h10);
    rchk(`EPI_OFS_RIS, 32'h0);
    rchk(`EPI_OFS_ERR, 32'h0);
    rchk(chb(0) + 12'h8, 32'h0);
    rchk(chb(1) + 12'h8, 32'h0);
    rchk(`EPI_OFS_FIFOLVL, 32'h0);
    chk({31'h0, if_enable}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask : t_reset
  task automatic t_modes();
    epi_mode_e ml [5] = '{mode_off, mode_sync_dram, mode_host_bus_narrow, mode_host_bus_wide, mode_general_purpose};
    foreach (ml[i]) begin
      wr(`EPI_OFS_MODE, {27'h0, ml[i]});
      rchk(`EPI_OFS_MODE, {27'h0, ml[i]});
      chk({27'h0, mode}, {27'h0, ml[i]});
      chk({31'h0, if_enable}, {31'h0, ml[i] != mode_off});
    end
    wr(`EPI_OFS_MODE, 32'h3);
    rchk(`EPI_OFS_MODE, 32'h1);
  endtask : t_modes
  task automatic t_fetch();
    go(0, item_size_byte, 32'h10, 32'h3);
    poll(`EPI_OFS_FIFOLVL, 32'h3);
    rchk(chb(0) + 12'h8, 32'h0);
    pop(0, item_size_byte, 3);
    wr(chb(0) + 12'h8, 32'h2);
    poll(`EPI_OFS_FIFOLVL, 32'h2);
    pop(0, item_size_byte, 2);
    go(1, item_size_word, 32'h100, 32'h2);
    poll(`EPI_OFS_FIFOLVL, 32'h2);
    pop(1, item_size_word, 2);
    slow <= 1'b1;
    go(1, item_size_half, 32'h202, 32'h3);
    poll(`EPI_OFS_FIFOLVL, 32'h3);
    pop(1, item_size_half, 3);
    slow <= 1'b0;
    wr(chb(0) + 12'h8, 32'h0);
    rchk(chb(0) + 12'h8, 32'h0);
    rchk(`EPI_OFS_FIFOLVL, 32'h0);
  endtask : t_fetch
  task automatic t_full();
    go(0, item_size_half, 32'h40, 32'ha);
    poll(`EPI_OFS_FIFOLVL, 32'h8);
    repeat (10) @(posedge ref_clk);
    rchk(`EPI_OFS_FIFOLVL, 32'h8);
    rchk(chb(0) + 12'h8, 32'h2);
    pop(0, item_size_half, 1);
    poll(`EPI_OFS_FIFOLVL, 32'h8);
    rchk(chb(0) + 12'h8, 32'h1);
    pop(0, item_size_half, 1);
    poll(`EPI_OFS_FIFOLVL, 32'h8);
    rchk(chb(0) + 12'h8, 32'h0);
    pop(0, item_size_half, 8);
  endtask : t_full
  task automatic t_err();
    int r0;
    wr(`EPI_OFS_ERRCLR, 32'h7);
    rchk(`EPI_OFS_ERR, 32'h0);
    wr(`EPI_OFS_MAXWAIT, 32'h4);
    hold <= 1'b1;
    go(1, item_size_word, 32'h80, 32'h5);
    repeat (12) @(posedge ref_clk);
    wr(chb(1) + 12'hc, 32'h1);
    repeat (2) @(posedge ref_clk);
    hold <= 1'b0;
    r0 = rd_seen;
    repeat (20) @(posedge ref_clk);
    chk(32'(rd_seen - r0), 32'h0);
    rchk(`EPI_OFS_FIFOLVL, 32'h0);
    rchk(`EPI_OFS_ERR, 32'h6);
    wr_attempt <= 1'b1;
    @(posedge ref_clk);
    wr_attempt <= 1'b0;
    wr_queue_full <= 1'b1;
    @(posedge ref_clk);
    rchk(`EPI_OFS_ERR, 32'h6);
    wr_attempt <= 1'b1;
    @(posedge ref_clk);
    wr_attempt <= 1'b0;
    wr_queue_full <= 1'b0;
    rchk(`EPI_OFS_ERR, 32'h7);
    rchk(`EPI_OFS_RIS, 32'h4);
    wr(`EPI_OFS_IM, 32'h0);
    rchk(`EPI_OFS_MIS, 32'h0);
    wr(`EPI_OFS_IM, 32'h7);
    rchk(`EPI_OFS_MIS, 32'h4);
    wr(`EPI_OFS_ERRCLR, 32'h1);
    rchk(`EPI_OFS_ERR, 32'h6);
    rchk(`EPI_OFS_RIS, 32'h4);
    wr(`EPI_OFS_ERRCLR, 32'h6);
    rchk(`EPI_OFS_ERR, 32'h0);
    rchk(`EPI_OFS_RIS, 32'h0);
    wr(`EPI_OFS_MAXWAIT, 32'h0);
  endtask : t_err
  task automatic t_req();
    tx_level <= 4'h1;
    rchk(`EPI_OFS_RIS, 32'h1);
    rchk(`EPI_OFS_MIS, 32'h1);
    tx_level <= 4'h2;
    rchk(`EPI_OFS_RIS, 32'h0);
    go(0, item_size_byte, 32'h3f0, 32'h5);
    poll(`EPI_OFS_FIFOLVL, 32'h5);
    rchk(`EPI_OFS_RIS, 32'h2);
    pop(0, item_size_byte, 1);
    rchk(`EPI_OFS_RIS, 32'h0);
    pop(0, item_size_byte, 4);
  endtask : t_req
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, then every scenario in turn.
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_modes();
    t_fetch();
    t_full();
    t_err();
    t_req();
    complete_run();
  end
endmodule : test_ext_bus_status_and_read_channels
